/* core/ddr_cmd_ctrl.sv */
// ddr command controller enforcing command spacing and write strobe protocol
// Operation
// - after a refresh, no activate or refresh is issued for 70 ns.
// - a read or write to a bank waits 15 ns after that bank's activate.
// - activates to different banks are at least 10 ns apart.
// - a read waits 2 cycles after the last write data.
// - any command waits 10 ns after a mode register set.
// - refresh_due is raised when refreshes fall behind an average of one every 1.95 us.
// - a read waits 200 cycles after leaving self refresh.
// - any other command waits 75 ns after leaving self refresh.
// - after write with auto precharge, the bank is not activated before write recovery plus precharge.
// - no more than eight refreshes are posted ahead of schedule.
// - the strobe goes from released to driven low before the first write edge.
// - the write postamble may be stretched beyond 0.6 clock periods.
`include "ddr_timing_params.svh"
module ddr_cmd_ctrl
  import ddr_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       req_valid,
  input  wire logic [2:0] req_cmd,
  input  wire logic [1:0] req_bank,
  input  wire logic       req_autopre,
  input  wire logic [3:0] post_cycles,
  output logic            req_ready,
  output logic            refresh_due,
  output logic            row_expiring,
  output logic [2:0]      cmd_out,
  output logic [1:0]      bank_out,
  output logic            autopre_out,
  output logic            dqs_out,
  output logic            dqs_oe
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  cmd_type    cmd;
  logic       issue;
  logic       t_rfc_ok;
  logic       t_rrd_ok;
  logic       t_mrd_ok;
  logic       t_xsnr_ok;
  logic       t_xsrd_ok;
  logic       t_wtr_ok;
  logic       t_wr_ok;
  logic       ld_rfc;
  logic       ld_rrd;
  logic       ld_mrd;
  logic       ld_srx;
  logic       ld_wtr;
  logic       strobe_last;
  logic       strobe_busy;
  logic       strobe_dqs;
  logic       strobe_oe;
  logic [3:0] bank_ok;
  logic [3:0] bank_act_ok;
  logic [3:0] bank_pre_ok;
  logic [3:0] bank_open;
  logic [3:0] bank_expiring;
  logic       legal;

  assign cmd = cmd_type'(req_cmd);

  gap_timer u_rfc (
    .clk   (clk),
    .rst_b (rst_sync_reg),
    .load  (ld_rfc),
    .count (16'(`C_RFC)),
    .ready (t_rfc_ok)
  );
  gap_timer u_rrd (
    .clk   (clk),
    .rst_b (rst_sync_reg),
    .load  (ld_rrd),
    .count (16'(`C_RRD)),
    .ready (t_rrd_ok)
  );
  gap_timer u_mrd (
    .clk   (clk),
    .rst_b (rst_sync_reg),
    .load  (ld_mrd),
    .count (16'(`C_MRD)),
    .ready (t_mrd_ok)
  );
  gap_timer u_xsnr (
    .clk   (clk),
    .rst_b (rst_sync_reg),
    .load  (ld_srx),
    .count (16'(`C_XSNR)),
    .ready (t_xsnr_ok)
  );
  gap_timer u_xsrd (
    .clk   (clk),
    .rst_b (rst_sync_reg),
    .load  (ld_srx),
    .count (16'(`C_XSRD)),
    .ready (t_xsrd_ok)
  );
  gap_timer u_wtr (
    .clk   (clk),
    .rst_b (rst_sync_reg),
    .load  (ld_wtr),
    .count (16'(`C_WTR)),
    .ready (t_wtr_ok)
  );
  gap_timer u_wr (
    .clk   (clk),
    .rst_b (rst_sync_reg),
    .load  (ld_wtr),
    .count (16'(`C_WR)),
    .ready (t_wr_ok)
  );

  assign ld_rfc = issue && (cmd == CMD_REF);
  assign ld_rrd = issue && (cmd == CMD_ACT);
  assign ld_mrd = issue && (cmd == CMD_MRS);
  assign ld_srx = issue && (cmd == CMD_SRX);
  assign ld_wtr = strobe_last;

  // per-bank row timers: activate, precharge and auto-precharge spacing
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_bank
      logic [15:0] rcd_reg, rcd_next;
      logic [15:0] ras_reg, ras_next;
      logic [15:0] rc_reg, rc_next;
      logic [15:0] rp_reg, rp_next;
      logic        open_reg, open_next;
      logic        apw_reg, apw_next;
      logic        hit;
      assign hit = issue && (req_bank == 2'(b));
      always_comb begin
        rcd_next  = (rcd_reg != 16'h0000) ? rcd_reg - 16'h0001 : rcd_reg;
        ras_next  = (ras_reg != 16'hffff) ? ras_reg + 16'h0001 : ras_reg;
        rc_next   = (rc_reg != 16'h0000) ? rc_reg - 16'h0001 : rc_reg;
        rp_next   = (rp_reg != 16'h0000) ? rp_reg - 16'h0001 : rp_reg;
        open_next = open_reg;
        apw_next  = apw_reg;
        if (hit && cmd == CMD_ACT) begin
          rcd_next  = 16'(`C_RCD);
          rc_next   = 16'(`C_RC);
          ras_next  = 16'h0001;
          open_next = 1'b1;
        end
        if (hit && cmd == CMD_PRE) begin
          rp_next   = 16'(`C_RP);
          open_next = 1'b0;
        end
        if (hit && cmd == CMD_WR && req_autopre) begin
          apw_next  = 1'b1;
          open_next = 1'b0;
        end
        // wait covers recovery plus precharge after the final data
        if (apw_reg && strobe_last) begin
          apw_next = 1'b0;
          rp_next  = 16'(`C_WR + `C_RP);
        end
        if (hit && cmd == CMD_REF) begin
          open_next = 1'b0;
        end
      end
      always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
          rcd_reg  <= 16'h0000;
          ras_reg  <= 16'h0000;
          rc_reg   <= 16'h0000;
          rp_reg   <= 16'h0000;
          open_reg <= 1'b0;
          apw_reg  <= 1'b0;
        end else begin
          rcd_reg  <= rcd_next;
          ras_reg  <= ras_next;
          rc_reg   <= rc_next;
          rp_reg   <= rp_next;
          open_reg <= open_next;
          apw_reg  <= apw_next;
        end
      end
      assign bank_ok[b]       = (rcd_reg <= 16'h0001);
      assign bank_act_ok[b]   = (rc_reg <= 16'h0001) && (rp_reg <= 16'h0001) && !apw_reg;
      assign bank_pre_ok[b]   = (ras_reg >= 16'(`C_RAS)) || !open_reg;
      assign bank_open[b]     = open_reg;
      // warn a few cycles before the longest open time so the row can be closed
      assign bank_expiring[b] = open_reg && (ras_reg >= 16'(`C_RAS_MAX - 16));
    end
  endgenerate

  // refresh schedule credit: positive means refreshes posted ahead
  logic [15:0]       refi_reg;
  logic [15:0]       refi_next;
  logic signed [4:0] credit_reg;
  logic signed [4:0] credit_next;
  logic              tick;
  assign tick = (refi_reg == 16'h0000);
  always_comb begin
    refi_next   = tick ? 16'(`C_REFI - 1) : refi_reg - 16'h0001;
    credit_next = credit_reg;
    if (issue && cmd == CMD_REF && !tick) begin
      credit_next = credit_reg + 5'sd1;
    // saturate so a long refresh stall cannot wrap into a posted credit
    end else if (!(issue && cmd == CMD_REF) && tick && credit_reg != 5'sh10) begin
      credit_next = credit_reg - 5'sd1;
    end
  end
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      refi_reg   <= 16'h0000;
      credit_reg <= 5'sd0;
    end else begin
      refi_reg   <= refi_next;
      credit_reg <= credit_next;
    end
  end

  // legality check of the presented command against all spacing timers
  always_comb begin
    legal = t_mrd_ok && t_xsnr_ok && !strobe_busy;
    case (cmd)
      CMD_NOP: legal = 1'b0;
      CMD_ACT: legal = legal && t_rfc_ok && t_rrd_ok && bank_act_ok[req_bank];
      CMD_RD:  legal = legal && bank_open[req_bank] && bank_ok[req_bank]
                       && t_wtr_ok && t_xsrd_ok;
      CMD_WR:  legal = legal && bank_open[req_bank] && bank_ok[req_bank];
      CMD_PRE: legal = legal && t_wr_ok && bank_pre_ok[req_bank];
      CMD_REF: legal = legal && t_rfc_ok && (bank_open == 4'h0)
                       && (credit_reg < $signed(5'(`MAX_POSTED)));
      CMD_MRS: legal = legal && (bank_open == 4'h0);
      CMD_SRX: legal = legal;
      default: legal = 1'b0;
    endcase
  end
  assign issue = req_valid && legal && rst_sync_reg;

  write_strobe u_strobe (
    .clk         (clk),
    .rst_b       (rst_sync_reg),
    .start       (issue && cmd == CMD_WR),
    .post_cycles (post_cycles),
    .dqs_out     (strobe_dqs),
    .dqs_oe      (strobe_oe),
    .last_beat   (strobe_last),
    .busy        (strobe_busy)
  );

  // registered outputs
  logic [2:0] cmd_reg,   cmd_next;
  logic [1:0] bank_reg,  bank_next;
  logic       ap_reg,    ap_next;
  logic       rdy_reg,   rdy_next;
  logic       due_reg,   due_next;
  logic       exp_reg,   exp_next;
  logic       dqs_reg,   dqs_next;
  logic       oe_reg,    oe_next;
  always_comb begin
    cmd_next  = issue ? req_cmd : 3'h0;
    bank_next = issue ? req_bank : 2'h0;
    ap_next   = issue && req_autopre;
    rdy_next  = issue;
    due_next  = (credit_reg < 5'sd0);
    exp_next  = (bank_expiring != 4'h0);
    dqs_next  = strobe_dqs;
    oe_next   = strobe_oe;
  end
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cmd_reg  <= 3'h0;
      bank_reg <= 2'h0;
      ap_reg   <= 1'b0;
      rdy_reg  <= 1'b0;
      due_reg  <= 1'b0;
      exp_reg  <= 1'b0;
      dqs_reg  <= 1'b0;
      oe_reg   <= 1'b0;
    end else begin
      cmd_reg  <= cmd_next;
      bank_reg <= bank_next;
      ap_reg   <= ap_next;
      rdy_reg  <= rdy_next;
      due_reg  <= due_next;
      exp_reg  <= exp_next;
      dqs_reg  <= dqs_next;
      oe_reg   <= oe_next;
    end
  end
  assign cmd_out      = cmd_reg;
  assign bank_out     = bank_reg;
  assign autopre_out  = ap_reg;
  assign req_ready    = rdy_reg;
  assign refresh_due  = due_reg;
  assign row_expiring = exp_reg;
  assign dqs_out      = dqs_reg;
  assign dqs_oe       = oe_reg;
endmodule // ddr_cmd_ctrl

/* core/ddr_ctrl_pkg.sv */
// types for the ddr command-spacing controller
package ddr_ctrl_pkg;
  typedef enum logic [2:0] {
    CMD_NOP  = 3'h0,
    CMD_ACT  = 3'h1,
    CMD_RD   = 3'h2,
    CMD_WR   = 3'h3,
    CMD_PRE  = 3'h4,
    CMD_REF  = 3'h5,
    CMD_MRS  = 3'h6,
    CMD_SRX  = 3'h7
  } cmd_type;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WPRE  = 4'b0010,
    ST_WDATA = 4'b0100,
    ST_WPST  = 4'b1000
  } strobe_state_type;
endpackage

/* core/ddr_timing_params.svh */
// timing constants for the ddr command-spacing controller
`ifndef DDR_TIMING_PARAMS_SVH
`define DDR_TIMING_PARAMS_SVH
`define CLK_PERIOD_PS        10000
`define T_RFC_NS             70
`define T_RCD_NS             15
`define T_RRD_NS             10
`define T_MRD_NS             10
`define T_XSNR_NS            75
`define T_RAS_NS             40
`define T_RAS_MAX_NS         70000
`define T_RC_NS              55
`define T_RP_NS              15
`define T_WR_NS              15
`define T_REFI_NS            1950
`define CYC_MIN(ns)          (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_MAX(ns)          (((ns) * 1000) / `CLK_PERIOD_PS)
`define C_RFC                `CYC_MIN(`T_RFC_NS)
`define C_RCD                `CYC_MIN(`T_RCD_NS)
`define C_RRD                `CYC_MIN(`T_RRD_NS)
`define C_MRD                `CYC_MIN(`T_MRD_NS)
`define C_XSNR               `CYC_MIN(`T_XSNR_NS)
`define C_RAS                `CYC_MIN(`T_RAS_NS)
`define C_RAS_MAX            `CYC_MAX(`T_RAS_MAX_NS)
`define C_RC                 `CYC_MIN(`T_RC_NS)
`define C_RP                 `CYC_MIN(`T_RP_NS)
`define C_WR                 `CYC_MIN(`T_WR_NS)
`define C_WTR                2
`define C_XSRD               200
`define C_REFI               `CYC_MAX(`T_REFI_NS)
`define MAX_POSTED           8
`define BURST_BEATS          2
`endif

/* core/gap_timer.sv */
// down-counting gap timer: ready when the programmed wait has elapsed
`include "ddr_timing_params.svh"
module gap_timer (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        load,
  input  wire logic [15:0] count,
  output logic             ready
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = count;
    end else if (cnt_reg != 16'h0000) begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  // a load of n means the next command may issue n cycles later;
  // ready ignores load so the issue decision never loops back on itself
  assign ready = (cnt_reg <= 16'h0001);
endmodule // gap_timer

/* core/write_strobe.sv */
// write strobe sequencer: preamble low, held high through the burst, low postamble
`include "ddr_timing_params.svh"
module write_strobe
  import ddr_ctrl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic start,
  input  wire logic [3:0] post_cycles,
  output logic      dqs_out,
  output logic      dqs_oe,
  output logic      last_beat,
  output logic      busy
);
  strobe_state_type st_reg;
  strobe_state_type st_next;
  logic [3:0]       cnt_reg;
  logic [3:0]       cnt_next;
  logic             dqs_reg;
  logic             dqs_next;
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    dqs_next  = 1'b0;
    last_beat = 1'b0;
    case (st_reg)
      ST_IDLE: begin
        if (start) begin
          st_next = ST_WPRE;
        end
      end
      ST_WPRE: begin
        st_next  = ST_WDATA;
        cnt_next = 4'h0;
        dqs_next = 1'b1;
      end
      ST_WDATA: begin
        dqs_next = 1'b1;
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(`BURST_BEATS - 1)) begin
          st_next   = ST_WPST;
          cnt_next  = 4'h0;
          dqs_next  = 1'b0;
          last_beat = 1'b1;
        end
      end
      ST_WPST: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg >= post_cycles) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg  <= ST_IDLE;
      cnt_reg <= 4'h0;
      dqs_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      dqs_reg <= dqs_next;
    end
  end
  assign dqs_out = dqs_reg;
  // driven low from idle before the first edge; postamble may be stretched
  assign dqs_oe  = (st_reg != ST_IDLE);
  assign busy    = (st_reg != ST_IDLE);
endmodule // write_strobe

/* verification/ddr_cmd_ctrl_monitor.sv */
// port assertions for the ddr command controller
module ddr_cmd_ctrl_monitor
  import ddr_ctrl_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       req_valid,
  input wire logic [2:0] req_cmd,
  input wire logic [1:0] req_bank,
  input wire logic       req_autopre,
  input wire logic [3:0] post_cycles,
  input wire logic       req_ready,
  input wire logic       refresh_due,
  input wire logic       row_expiring,
  input wire logic [2:0] cmd_out,
  input wire logic [1:0] bank_out,
  input wire logic       autopre_out,
  input wire logic       dqs_out,
  input wire logic       dqs_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles since self refresh exit, saturating so reset looks long ago
  logic [7:0] srx_cnt_reg;
  logic [7:0] srx_cnt_next;
  always_comb begin
    srx_cnt_next = srx_cnt_reg;
    if (cmd_out == CMD_SRX) begin
      srx_cnt_next = 8'h01;
    end else if (srx_cnt_reg != 8'hFF) begin
      srx_cnt_next = srx_cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      srx_cnt_reg <= 8'hFF;
    end else begin
      srx_cnt_reg <= srx_cnt_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_rfc_gap: assert property (
    cmd_out == CMD_REF |=> (cmd_out != CMD_ACT && cmd_out != CMD_REF) [*6])
    else $error("refresh cycle gap broken");
  chk_rcd_gap: assert property (
    cmd_out == CMD_ACT |=> !(cmd_out inside {CMD_RD, CMD_WR} && bank_out == $past(bank_out)))
    else $error("column command too soon after activate");
  chk_wtr_gap: assert property (
    dqs_oe && $fell(dqs_out) |-> cmd_out != CMD_RD)
    else $error("read too soon after write data");
  chk_xsrd_gap: assert property (
    cmd_out == CMD_RD |-> srx_cnt_reg >= 8'hC8)
    else $error("read too soon after self refresh exit");
  chk_xsnr_gap: assert property (
    !(cmd_out inside {CMD_NOP, CMD_RD}) |-> srx_cnt_reg >= 8'h08)
    else $error("command too soon after self refresh exit");
  chk_wr_strobe: assert property (
    cmd_out == CMD_WR |=> dqs_oe && !dqs_out ##1 (dqs_oe && dqs_out) [*2] ##1 dqs_oe && !dqs_out)
    else $error("write strobe shape wrong");
  chk_ras_min: assert property (
    cmd_out == CMD_ACT |=> !(cmd_out == CMD_PRE && bank_out == $past(bank_out, 1))
      ##1 !(cmd_out == CMD_PRE && bank_out == $past(bank_out, 2))
      ##1 !(cmd_out == CMD_PRE && bank_out == $past(bank_out, 3)))
    else $error("row closed too early");
  chk_rp_gap: assert property (
    cmd_out == CMD_PRE |=> !(cmd_out == CMD_ACT && bank_out == $past(bank_out)))
    else $error("activate too soon after precharge");
  chk_ready_cmd: assert property (
    req_ready |-> $past(req_valid) && cmd_out == $past(req_cmd) && bank_out == $past(req_bank)
      && autopre_out == $past(req_autopre))
    else $error("issued command differs from request");
  cov_write: cover property (cmd_out == CMD_WR ##1 dqs_oe);
  cov_srx_read: cover property (cmd_out == CMD_RD && srx_cnt_reg == 8'hC8);
  cov_ref_held: cover property ((req_valid && req_cmd == CMD_REF && !req_ready) [*8]);
endmodule // ddr_cmd_ctrl_monitor
bind ddr_cmd_ctrl ddr_cmd_ctrl_monitor ddr_cmd_ctrl_monitor_i (.*);

/* verification/ddr_cmd_ctrl_test.sv */
// self-checking bench for the ddr command controller
`include "ddr_timing_params.svh"
module ddr_cmd_ctrl_test
  import ddr_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0;
  logic        rst_b = 0;
  logic        req_valid = 0;
  logic [2:0]  req_cmd = 3'h0;
  logic [1:0]  req_bank = 2'h0;
  logic        req_autopre = 0;
  logic [3:0]  post_cycles = 4'h0;
  logic        req_ready;
  logic        refresh_due;
  logic        row_expiring;
  logic [2:0]  cmd_out;
  logic [1:0]  bank_out;
  logic        autopre_out;
  logic        dqs_out;
  logic        dqs_oe;
  int          viol;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [31:0] rnd = 32'h0000_e29b;
  int          e[$];
  initial forever #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  ddr_cmd_ctrl ddr_cmd_ctrl_i (.*);
  ddr_device_model ddr_device_model_i (.clk(clk), .cmd(cmd_out), .bank(bank_out),
    .ap(autopre_out), .dqs(dqs_out), .dqs_en(dqs_oe), .viol(viol));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // request stays up when not last, so the next one follows without a gap
  task automatic issue(input cmd_type c, input logic [1:0] b, input logic ap,
                       input int lim, input bit last);
    int n;
    n = 0;
    // a lowered request lets one edge pass before the next is raised
    if (!req_valid) begin
      @(posedge clk);
      #1;
    end
    req_valid = 1;
    req_cmd = c;
    req_bank = b;
    req_autopre = ap;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (req_ready !== 1'b1 && n < lim);
    e.push_back(req_ready === 1'b1 ? cyc : -1);
    if (last) req_valid = 0;
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    int k;
    int w;
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1;
    repeat (5) @(posedge clk);
    #1;
    chk_bit(refresh_due, 1'b1);
    for (k = 0; k < 9; k++) issue(CMD_REF, 2'h0, 1'b0, 20, 1'b0);
    for (k = 1; k < 9; k++) chk(e[k] - e[k-1], `C_RFC);
    chk_bit(refresh_due, 1'b0);
    issue(CMD_REF, 2'h0, 1'b0, 100, 1'b0);
    chk(e[9], -1);
    issue(CMD_REF, 2'h0, 1'b0, 300, 1'b1);
    chk(int'(e[10] > e[8] + 100), 1);
    e.delete();
    issue(CMD_ACT, 2'h0, 1'b0, 20, 1'b0);
    issue(CMD_ACT, 2'h1, 1'b0, 20, 1'b0);
    issue(CMD_RD, 2'h0, 1'b0, 20, 1'b0);
    issue(CMD_PRE, 2'h1, 1'b0, 20, 1'b0);
    issue(CMD_ACT, 2'h1, 1'b0, 20, 1'b1);
    chk(e[1] - e[0], `C_RRD);
    chk(e[2] - e[0], `C_RCD);
    chk(e[3] - e[1], `C_RAS);
    chk(e[4] - e[1], `C_RC);
    for (k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      post_cycles = rnd[3:0];
      e.delete();
      issue(CMD_WR, 2'(k & 1), k == 3, 20, 1'b1);
      for (w = 1; w <= int'(post_cycles) + 5; w++) begin
        @(posedge clk);
        #1;
        chk_bit(dqs_oe, w <= post_cycles + 4);
        if (w < post_cycles + 5) chk_bit(dqs_out, w == 2 || w == 3);
      end
      issue(k == 3 ? CMD_ACT : CMD_RD, 2'(k & 1), 1'b0, 30, 1'b1);
      chk(int'(e[1] >= e[0] + (k == 3 ? 7 : 5)), 1);
    end
    e.delete();
    issue(CMD_PRE, 2'h0, 1'b0, 20, 1'b0);
    issue(CMD_PRE, 2'h1, 1'b0, 20, 1'b0);
    issue(CMD_SRX, 2'h0, 1'b0, 20, 1'b0);
    issue(CMD_ACT, 2'h2, 1'b0, 20, 1'b0);
    issue(CMD_RD, 2'h2, 1'b0, 300, 1'b0);
    issue(CMD_PRE, 2'h2, 1'b0, 20, 1'b0);
    issue(CMD_MRS, 2'h0, 1'b0, 20, 1'b0);
    issue(CMD_ACT, 2'h3, 1'b0, 20, 1'b1);
    chk(e[3] - e[2], `C_XSNR);
    chk(e[4] - e[2], `C_XSRD);
    chk(e[7] - e[6], `C_MRD);
    repeat (6960) @(posedge clk);
    #1;
    chk_bit(row_expiring, 1'b0);
    repeat (30) @(posedge clk);
    #1;
    chk_bit(row_expiring, 1'b1);
    chk_bit(refresh_due, 1'b1);
    chk(viol, 0);
    stop_test();
  end
endmodule // ddr_cmd_ctrl_test

/* verification/ddr_device_model.sv */
// dram device model: counts command spacing faults it receives
`include "ddr_timing_params.svh"
module ddr_device_model
  import ddr_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [2:0] cmd,
  input  wire logic [1:0] bank,
  input  wire logic       ap,
  input  wire logic       dqs,
  input  wire logic       dqs_en,
  output int              viol
);
  timeunit 1ns;
  timeprecision 1ps;
  int         t = 0;
  int         refs = 0;
  int         t_ref = -999;
  int         t_mrs = -999;
  int         t_srx = -999;
  int         t_wend = -999;
  int         t_act[4] = '{default: -999};
  int         t_pre[4] = '{default: -999};
  logic [1:0] wbank = 2'h0;
  logic       wap = 1'b0;
  logic       en_q = 1'b0;
  logic       dqs_q = 1'b0;
  initial viol = 0;
  task automatic need(input bit ok);
    if (!ok) viol++;
  endtask
  always @(posedge clk) begin
    t++;
    if (dqs_en && !en_q) need(!dqs);
    // any postamble length is accepted, only the falling edge ends the burst
    if (dqs_en && dqs_q && !dqs) begin
      t_wend = t;
      if (wap) t_pre[wbank] = t + 1;
    end
    if (cmd != CMD_NOP) need(t - t_mrs >= `C_MRD);
    if (!(cmd inside {CMD_NOP, CMD_RD})) need(t - t_srx >= `C_XSNR);
    case (cmd)
      CMD_ACT: begin
        need(t - t_ref >= `C_RFC && t - t_pre[bank] >= `C_RP);
        need(t - t_act[bank] >= `C_RC);
        t_act[bank] = t;
      end
      CMD_RD: begin
        need(t - t_act[bank] >= `C_RCD && t - t_wend >= 1);
        need(t - t_srx >= `C_XSRD);
      end
      CMD_WR: begin
        need(t - t_act[bank] >= `C_RCD);
        wbank = bank;
        wap = ap;
      end
      CMD_PRE: begin
        need(t - t_act[bank] >= `C_RAS && t - t_wend >= 1);
        t_pre[bank] = t;
      end
      CMD_REF: begin
        need(t - t_ref >= `C_RFC);
        refs++;
        need(refs <= t / `C_REFI + 9);
        t_ref = t;
      end
      CMD_MRS: t_mrs = t;
      CMD_SRX: t_srx = t;
      default: ;
    endcase
    en_q = dqs_en;
    dqs_q = dqs;
  end
endmodule // ddr_device_model
